// >>> core/cpom_regs.vh
// Constants for the cell physical layer maintenance monitor.
`ifndef CPOM_REGS_VH
`define CPOM_REGS_VH
// Register offsets of the plain register port.
`define CPOM_OFS_CTRL 4'h0
`define CPOM_OFS_OAMGAP 4'h1
`define CPOM_OFS_STATUS 4'h2
`define CPOM_OFS_STATE 4'h3
`define CPOM_OFS_PAIS 4'h4
`define CPOM_OFS_SRDI 4'h5
`define CPOM_OFS_PRDI 4'h6
`define CPOM_OFS_RXOCT 4'h7
// Control register fields.
`define CPOM_CTRL_SIDE 0
`define CPOM_CTRL_WORK 1
`define CPOM_CTRL_X_LSB 2
`define CPOM_CTRL_X_MSB 4
`define CPOM_CTRL_RST 8'h03
// Defect octet bit positions.
`define CPOM_BIT_SUM 0
`define CPOM_BIT_LOS 1
`define CPOM_BIT_LCD 2
`define CPOM_BIT_LOM 3
`define CPOM_BIT_AIS 4
// Fixed pattern of octet 2 in F1 cells.
`define CPOM_F1_RSVD 8'h6a
// Octet positions inside the OAM payload.
`define CPOM_OCT_AIS 6'd2
`define CPOM_OCT_RDI 6'd30
// Delineation state codes.
`define CPOM_DL_HUNT 2'd0
`define CPOM_DL_PRESYNC 2'd1
`define CPOM_DL_SYNC 2'd2
// Timing: one millisecond in cycles of a 100 ns clock.
`define CPOM_MS_NS 1000000
`define CPOM_CLK_NS 100
`define CPOM_MS_CYC (`CPOM_MS_NS / `CPOM_CLK_NS)
// Default largest gap between OAM cells, in cycles.
`define CPOM_GAP_RST 16'h4000
// State codes, user side F1..F7, network side G1..G13 (bit 4 marks G).
`define CPOM_F1 5'h01
`define CPOM_F2 5'h02
`define CPOM_F3 5'h03
`define CPOM_F4 5'h04
`define CPOM_F5 5'h05
`define CPOM_F6 5'h06
`define CPOM_F7 5'h07
`define CPOM_G1 5'h11
`define CPOM_G2 5'h12
`define CPOM_G4 5'h14
`define CPOM_G5 5'h15
`define CPOM_G10 5'h1a
`define CPOM_G13 5'h1d
`endif

// >>> core/cpom_lom_det.v
// Loss of maintenance flow detector for one OAM flow.
`timescale 1ns/1ps
`default_nettype none
module cpom_lom_det #(
  parameter GW = 16
) (
  input wire clk,
  input wire rst,
  input wire cell_seen,
  input wire [GW-1:0] max_gap,
  output reg miss_q,
  output reg lom_q
);
  reg [GW-1:0] gap_q;
  reg miss_seen_q;

  // ****************************************
  // Gap timer and two-miss declaration.
  // ****************************************
  // A received cell restarts the timer and clears both the miss memory and LOM.
  always @(posedge clk) begin
    if (rst) begin
      gap_q <= {GW{1'b0}};
      miss_q <= 1'b0;
      miss_seen_q <= 1'b0;
      lom_q <= 1'b0;
    end else if (cell_seen) begin
      gap_q <= {GW{1'b0}};
      miss_q <= 1'b0;
      miss_seen_q <= 1'b0;
      lom_q <= 1'b0;
    end else if (gap_q >= max_gap) begin
      gap_q <= {GW{1'b0}};
      miss_q <= 1'b1;
      miss_seen_q <= 1'b1;
      if (miss_seen_q) begin
        lom_q <= 1'b1;
      end
    end else begin
      gap_q <= gap_q + {{(GW-1){1'b0}}, 1'b1};
      miss_q <= 1'b0;
    end
  end
endmodule // cpom_lom_det
`default_nettype wire

// >>> core/cpom_lcd_det.v
// Out of cell delineation and loss of cell delineation detector.
`timescale 1ns/1ps
`default_nettype none
`include "cpom_regs.vh"
module cpom_lcd_det #(
  parameter CW = 16
) (
  input wire clk,
  input wire rst,
  input wire [1:0] dl_state,
  input wire working,
  input wire [CW-1:0] x_cycles,
  output reg ocd_q,
  output reg lcd_q
);
  reg [1:0] dl_prev_q;
  reg [CW-1:0] cnt_q;

  // ****************************************
  // Anomaly and defect tracking.
  // ****************************************
  // One counter serves both the set and the clear timing, since they never overlap.
  always @(posedge clk) begin
    if (rst) begin
      dl_prev_q <= `CPOM_DL_HUNT;
      ocd_q <= 1'b0;
      lcd_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
    end else begin
      dl_prev_q <= dl_state;
      if (!lcd_q) begin
        if (ocd_q) begin
          if (dl_prev_q == `CPOM_DL_PRESYNC && dl_state == `CPOM_DL_SYNC) begin
            ocd_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
          end else if (cnt_q >= x_cycles - {{(CW-1){1'b0}}, 1'b1}) begin
            ocd_q <= 1'b0;
            lcd_q <= 1'b1;
            cnt_q <= {CW{1'b0}};
          end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
          end
        end else if (working && dl_prev_q == `CPOM_DL_SYNC && dl_state == `CPOM_DL_HUNT) begin
          ocd_q <= 1'b1;
          cnt_q <= {CW{1'b0}};
        end
      end else if (dl_state != `CPOM_DL_SYNC) begin
        cnt_q <= {CW{1'b0}};
      end else if (cnt_q >= x_cycles - {{(CW-1){1'b0}}, 1'b1}) begin
        lcd_q <= 1'b0;
        cnt_q <= {CW{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // cpom_lcd_det
`default_nettype wire

// >>> core/cpom_top.v
// Cell based interface layer 1 maintenance monitor and F/G state tracker.
// Functional notes
// - Flag a missed OAM cell when the largest allowed gap passes without one.
// - Declare LOM for a flow after two successive missed-cell anomalies.
// - Path alarm field is payload octet 2 of F3 cells, both directions.
// - Section remote defect field is payload octet 30 of F1 cells.
// - Path remote defect field is payload octet 30 of F3 cells.
// - OCD starts on a SYNC to HUNT move while working.
// - OCD ends on PRESYNC to SYNC or when LCD is declared.
// - LCD is declared after OCD persists x milliseconds, x from 1 to 4.
// - LCD clears after SYNC held x continuous milliseconds.
// - LOS and LCD made locally; alarms exchanged only through OAM cells.
// - User F1 sends and receives operational cells.
// - Received P-RDI without S-RDI gives F2, still sending operational cells.
// - Local LOS or LCD gives F3, sending S-RDI and P-RDI.
// - Received P-AIS gives F4, sending P-RDI.
// - Received S-RDI and P-RDI gives F5, still operational.
// - Received S-RDI and P-AIS gives F6, sending P-RDI.
// - Power-on states F7 and G13 left only after signal is classified.
// - Network access LCD gives G2, sending P-RDI without S-RDI.
// - Access LOS gives G4, sending P-AIS and dropping network timing.
// - Local LOS, LCD or LOM on user link gives G5, sending S-RDI and P-RDI.
// - Access LOS and user-link faults together give G10, sending P-AIS and S-RDI; access LCD with a user-link fault gives G5.
// - Path alarm octet carries LOM, LCD, LOS, summary bit, upper four zero.
// - Remote defect octet carries defects, summary, F3 adds P-AIS, upper zero.
// - Octet 2 of F1 cells is sent as 6A hex.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpom_regs.vh"
module cpom_top #(
  parameter GW = 16,
  parameter CW = 16
) (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire LOS,
  input wire [1:0] DL_STATE,
  input wire ACC_LOS,
  input wire ACC_LCD,
  input wire RX_OCT_VLD,
  input wire RX_F3,
  input wire [5:0] RX_OCT_IDX,
  input wire [7:0] RX_OCT,
  input wire RX_CELL_END,
  input wire TX_OCT_REQ,
  input wire TX_F3,
  input wire [5:0] TX_OCT_IDX,
  output reg [7:0] TX_OCT,
  output reg TX_OAM_ONLY,
  output reg NET_TIMING,
  output reg [4:0] STATE,
  output reg STATE_EVT,
  output reg LOM_F1,
  output reg LOM_F3,
  output reg LCD_OUT
);
  // ****************************************
  // Registers and local signals.
  // ****************************************
  reg [7:0] ctrl_q;
  reg [GW-1:0] gap_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg signal_ok_q;
  reg rx_srdi_q;
  reg rx_prdi_q;
  reg rx_pais_q;
  reg [7:0] rx_ais_oct_q;
  reg [7:0] rx_srdi_oct_q;
  reg [7:0] rx_prdi_oct_q;
  reg [7:0] pais_oct;
  reg [7:0] srdi_oct;
  reg [7:0] prdi_oct;
  reg send_srdi;
  reg send_prdi;
  reg send_pais;
  wire side_net;
  wire working;
  wire [2:0] x_ms;
  wire [CW-1:0] x_cycles;
  wire ocd;
  wire lcd;
  wire miss_f1;
  wire miss_f3;
  wire lom_f1;
  wire lom_f3;
  wire f1_seen;
  wire f3_seen;

  assign side_net = ctrl_q[`CPOM_CTRL_SIDE];
  assign working = ctrl_q[`CPOM_CTRL_WORK];
  assign x_ms = ctrl_q[`CPOM_CTRL_X_MSB:`CPOM_CTRL_X_LSB];
  // Out-of-range x values are clamped into 1..4 ms.
  assign x_cycles = ms_to_cyc((x_ms == 3'd0) ? 3'd1 : ((x_ms > 3'd4) ? 3'd4 : x_ms));
  assign f1_seen = RX_CELL_END && !RX_F3;
  assign f3_seen = RX_CELL_END && RX_F3;

  // Builds a defect octet; the summary bit is set when any defect is set.
  function [7:0] defect_oct;
    input lom_b;
    input lcd_b;
    input los_b;
    input ais_b;
    begin
      defect_oct = 8'h00;
      defect_oct[`CPOM_BIT_LOM] = lom_b;
      defect_oct[`CPOM_BIT_LCD] = lcd_b;
      defect_oct[`CPOM_BIT_LOS] = los_b;
      defect_oct[`CPOM_BIT_AIS] = ais_b;
      defect_oct[`CPOM_BIT_SUM] = lom_b | lcd_b | los_b | ais_b;
    end
  endfunction

  // Converts whole milliseconds to clock cycles.
  function [CW-1:0] ms_to_cyc;
    input [2:0] ms;
    reg [31:0] prod;
    begin
      prod = ms * `CPOM_MS_CYC;
      ms_to_cyc = prod[CW-1:0];
    end
  endfunction

  // ****************************************
  // Detectors.
  // ****************************************
  cpom_lcd_det #(.CW(CW)) u_lcd (
    .clk(CLK),
    .rst(RST),
    .dl_state(DL_STATE),
    .working(working),
    .x_cycles(x_cycles),
    .ocd_q(ocd),
    .lcd_q(lcd)
  );

  cpom_lom_det #(.GW(GW)) u_lom_f1 (
    .clk(CLK),
    .rst(RST),
    .cell_seen(f1_seen),
    .max_gap(gap_q),
    .miss_q(miss_f1),
    .lom_q(lom_f1)
  );

  cpom_lom_det #(.GW(GW)) u_lom_f3 (
    .clk(CLK),
    .rst(RST),
    .cell_seen(f3_seen),
    .max_gap(gap_q),
    .miss_q(miss_f3),
    .lom_q(lom_f3)
  );

  // ****************************************
  // Received indications.
  // ****************************************
  // Far-end alarms arrive only inside OAM cell octets and latch per cell.
  always @(posedge CLK) begin
    if (RST) begin
      rx_srdi_q <= 1'b0;
      rx_prdi_q <= 1'b0;
      rx_pais_q <= 1'b0;
      rx_ais_oct_q <= 8'h00;
      rx_srdi_oct_q <= 8'h00;
      rx_prdi_oct_q <= 8'h00;
      signal_ok_q <= 1'b0;
    end else begin
      if (RX_OCT_VLD && RX_F3 && RX_OCT_IDX == `CPOM_OCT_AIS) begin
        rx_ais_oct_q <= RX_OCT;
        rx_pais_q <= RX_OCT[`CPOM_BIT_SUM];
      end
      if (RX_OCT_VLD && !RX_F3 && RX_OCT_IDX == `CPOM_OCT_RDI) begin
        rx_srdi_oct_q <= RX_OCT;
        rx_srdi_q <= RX_OCT[`CPOM_BIT_SUM];
      end
      if (RX_OCT_VLD && RX_F3 && RX_OCT_IDX == `CPOM_OCT_RDI) begin
        rx_prdi_oct_q <= RX_OCT;
        rx_prdi_q <= RX_OCT[`CPOM_BIT_SUM];
      end
      // Signal counts as classified once synced with no LOS.
      if (!LOS && DL_STATE == `CPOM_DL_SYNC) begin
        signal_ok_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outgoing defect octets.
  // ****************************************
  // On the network side the access defects and user-link LOM must show, or G2 and G4 send empty octets.
  always @* begin
    pais_oct = defect_oct(lom_f3, lcd, LOS | (side_net & ACC_LOS), 1'b0);
    srdi_oct = defect_oct(lom_f1, lcd, LOS, 1'b0);
    prdi_oct = defect_oct(lom_f3 | (side_net & lom_f1), lcd | (side_net & ACC_LCD),
                          LOS, rx_pais_q);
  end

  // ****************************************
  // F and G state selection.
  // ****************************************
  // Priority goes to local faults, then to received alarms, for a stable state.
  always @* begin
    state_d = state_q;
    if (!side_net) begin
      if (state_q == `CPOM_F7 && !signal_ok_q) begin
        state_d = `CPOM_F7;
      end else if (LOS || lcd) begin
        state_d = `CPOM_F3;
      end else if (rx_srdi_q && rx_pais_q) begin
        state_d = `CPOM_F6;
      end else if (rx_pais_q) begin
        state_d = `CPOM_F4;
      end else if (rx_srdi_q && rx_prdi_q) begin
        state_d = `CPOM_F5;
      end else if (rx_prdi_q) begin
        state_d = `CPOM_F2;
      end else begin
        state_d = `CPOM_F1;
      end
    end else begin
      if (state_q == `CPOM_G13 && !signal_ok_q) begin
        state_d = `CPOM_G13;
      end else if (ACC_LOS && (LOS || lcd || lom_f1)) begin
        state_d = `CPOM_G10;
      end else if (ACC_LOS) begin
        state_d = `CPOM_G4;
      end else if (LOS || lcd || lom_f1) begin
        state_d = `CPOM_G5;
      end else if (ACC_LCD) begin
        state_d = `CPOM_G2;
      end else begin
        state_d = `CPOM_G1;
      end
    end
  end

  // What each state sends toward the far end.
  always @* begin
    send_srdi = 1'b0;
    send_prdi = 1'b0;
    send_pais = 1'b0;
    case (state_q)
      `CPOM_F3: begin
        send_srdi = 1'b1;
        send_prdi = 1'b1;
      end
      `CPOM_F4, `CPOM_F6, `CPOM_G2: begin
        send_prdi = 1'b1;
      end
      `CPOM_G4: begin
        send_pais = 1'b1;
      end
      `CPOM_G5: begin
        send_srdi = 1'b1;
        send_prdi = 1'b1;
      end
      `CPOM_G10: begin
        send_pais = 1'b1;
        send_srdi = 1'b1;
      end
      default: begin
        send_srdi = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register and transmit octets.
  // ****************************************
  // State change detection sits on the registered state so the event is one cycle.
  always @(posedge CLK) begin
    if (RST) begin
      state_q <= `CPOM_F7;
      STATE <= `CPOM_F7;
      STATE_EVT <= 1'b0;
      TX_OCT <= 8'h00;
      TX_OAM_ONLY <= 1'b0;
      NET_TIMING <= 1'b0;
      LOM_F1 <= 1'b0;
      LOM_F3 <= 1'b0;
      LCD_OUT <= 1'b0;
    end else begin
      if (side_net != state_q[4]) begin
        state_q <= side_net ? `CPOM_G13 : `CPOM_F7;
      end else begin
        state_q <= state_d;
      end
      STATE <= state_q;
      STATE_EVT <= (STATE != state_q);
      // Operational cells are replaced by OAM-only traffic in states F3, F4 and F6.
      TX_OAM_ONLY <= (state_q == `CPOM_F3) || (state_q == `CPOM_F4) || (state_q == `CPOM_F6);
      NET_TIMING <= side_net && (state_q != `CPOM_G4) && (state_q != `CPOM_G10) &&
                    (state_q != `CPOM_G13);
      LOM_F1 <= lom_f1;
      LOM_F3 <= lom_f3;
      LCD_OUT <= lcd;
      if (TX_OCT_REQ) begin
        if (TX_OCT_IDX == `CPOM_OCT_AIS) begin
          TX_OCT <= !TX_F3 ? `CPOM_F1_RSVD : (send_pais ? pais_oct : 8'h00);
        end else if (TX_OCT_IDX == `CPOM_OCT_RDI) begin
          TX_OCT <= TX_F3 ? (send_prdi ? prdi_oct : 8'h00) : (send_srdi ? srdi_oct : 8'h00);
        end else begin
          TX_OCT <= `CPOM_F1_RSVD;
        end
      end
    end
  end

  // ****************************************
  // Register port.
  // ****************************************
  // Reads answer in the next cycle only; unmapped addresses read zero.
  always @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= `CPOM_CTRL_RST;
      gap_q <= `CPOM_GAP_RST;
      RDATA <= 16'h0000;
    end else begin
      if (WR && ADDR == `CPOM_OFS_CTRL) begin
        ctrl_q <= WDATA[7:0];
      end
      if (WR && ADDR == `CPOM_OFS_OAMGAP) begin
        gap_q <= WDATA[GW-1:0];
      end
      RDATA <= 16'h0000;
      if (RD) begin
        case (ADDR)
          `CPOM_OFS_CTRL: RDATA <= {8'h00, ctrl_q};
          `CPOM_OFS_OAMGAP: RDATA <= gap_q;
          `CPOM_OFS_STATUS: RDATA <= {8'h00, miss_f3, miss_f1, rx_pais_q, rx_prdi_q, rx_srdi_q,
                                      lom_f3 | lom_f1, lcd, ocd};
          `CPOM_OFS_STATE: RDATA <= {11'h000, state_q};
          `CPOM_OFS_PAIS: RDATA <= {rx_ais_oct_q, pais_oct};
          `CPOM_OFS_SRDI: RDATA <= {rx_srdi_oct_q, srdi_oct};
          `CPOM_OFS_PRDI: RDATA <= {rx_prdi_oct_q, prdi_oct};
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule // cpom_top
`default_nettype wire

// >>> tb/cpom_properties.sv
// Concurrent checks on the ports of the maintenance monitor.
`timescale 1ns/1ps
`default_nettype none
`include "cpom_regs.vh"
module cpom_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [1:0] DL_STATE,
  input wire logic TX_OCT_REQ,
  input wire logic TX_F3,
  input wire logic [5:0] TX_OCT_IDX,
  input wire logic [7:0] TX_OCT,
  input wire logic [4:0] STATE,
  input wire logic STATE_EVT,
  input wire logic LCD_OUT
);
  // ***
  // Clocking
  // ***
  // One clock domain, so every check shares the clock and sleeps in reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ***
  // Properties
  // ***
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0)
    else $error("read data present without a read");
  a_evt_change: assert property (STATE != $past(STATE) |-> STATE_EVT)
    else $error("state moved without an event pulse");
  a_evt_only: assert property (STATE_EVT |-> STATE != $past(STATE))
    else $error("event pulse without a state change");
  a_f1_pattern: assert property (TX_OCT_REQ && !TX_F3
    && TX_OCT_IDX == `CPOM_OCT_AIS |=> TX_OCT == `CPOM_F1_RSVD)
    else $error("octet 2 of an F1 cell is not the fixed pattern");
  a_ais_code: assert property (TX_OCT_REQ && TX_F3
    && TX_OCT_IDX == `CPOM_OCT_AIS |=> TX_OCT[7:4] == 4'h0 && TX_OCT[0] == |TX_OCT[3:1])
    else $error("path alarm octet badly coded");
  a_rdi_code: assert property (TX_OCT_REQ && TX_OCT_IDX == `CPOM_OCT_RDI
    |=> TX_OCT[7:5] == 3'h0 && TX_OCT[0] == |TX_OCT[4:1] && ($past(TX_F3) || !TX_OCT[4]))
    else $error("remote defect octet badly coded");
  a_tx_hold: assert property (!TX_OCT_REQ |=> $stable(TX_OCT))
    else $error("transmit octet changed without a request");
  a_lcd_rise: assert property ($rose(LCD_OUT) |-> $past(DL_STATE) != `CPOM_DL_SYNC)
    else $error("loss of delineation declared while in sync");
  a_lcd_fall: assert property ($fell(LCD_OUT) |-> $past(DL_STATE) == `CPOM_DL_SYNC)
    else $error("loss of delineation cleared outside sync");
endmodule // cpom_properties
bind cpom_top cpom_properties i_cpom_properties (.*);
`default_nettype wire

// >>> tb/cpom_peer.sv
// Far end termination model: sends OAM cells and pulls transmit octets.
`timescale 1ns/1ps
`default_nettype none
`include "cpom_regs.vh"
module cpom_peer (
  input wire logic CLK,
  output logic RX_OCT_VLD,
  output logic RX_F3,
  output logic [5:0] RX_OCT_IDX,
  output logic [7:0] RX_OCT,
  output logic RX_CELL_END,
  output logic TX_OCT_REQ,
  output logic TX_F3,
  output logic [5:0] TX_OCT_IDX,
  input wire logic [7:0] TX_OCT
);
  // Quiet link at time zero.
  initial begin
    RX_OCT_VLD = 1'b0;
    RX_F3 = 1'b0;
    RX_OCT_IDX = 6'h0;
    RX_OCT = 8'h0;
    RX_CELL_END = 1'b0;
    TX_OCT_REQ = 1'b0;
    TX_F3 = 1'b0;
    TX_OCT_IDX = 6'h0;
  end
  // ***
  // Transfers
  // ***
  // A whole 48 octet cell; between octets the data line shows the inverse,
  // so a design that samples it without the strobe picks up junk.
  task automatic send_cell(input logic f3, input logic [7:0] ais, input logic [7:0] rdi);
    logic [7:0] v;
    for (int i = 1; i <= 48; i++) begin
      v = (i == 2 && f3) ? ais : (i == 30) ? rdi : `CPOM_F1_RSVD;
      @(posedge CLK);
      RX_OCT_VLD <= 1'b1;
      RX_F3 <= f3;
      RX_OCT_IDX <= i[5:0];
      RX_OCT <= v;
      @(posedge CLK);
      RX_OCT_VLD <= 1'b0;
      RX_OCT <= ~v;
    end
    RX_CELL_END <= 1'b1;
    @(posedge CLK);
    RX_CELL_END <= 1'b0;
  endtask
  // One octet request; the answer is registered at the edge that takes it.
  task automatic fetch(input logic f3, input logic [5:0] idx, output logic [7:0] v);
    @(posedge CLK);
    TX_OCT_REQ <= 1'b1;
    TX_F3 <= f3;
    TX_OCT_IDX <= idx;
    @(posedge CLK);
    TX_OCT_REQ <= 1'b0;
    #1 v = TX_OCT;
  endtask
endmodule // cpom_peer
`default_nettype wire

// >>> tb/tb_cpom_top.sv
// Self-checking bench for the maintenance monitor.
`timescale 1ns/1ps
`default_nettype none
`include "cpom_regs.vh"
module tb_cpom_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic LOS = 1'b0;
  logic [1:0] DL_STATE = `CPOM_DL_HUNT;
  logic ACC_LOS = 1'b0;
  logic ACC_LCD = 1'b0;
  wire [15:0] RDATA;
  wire [7:0] RX_OCT, TX_OCT;
  wire [5:0] RX_OCT_IDX, TX_OCT_IDX;
  wire [4:0] STATE;
  wire RX_OCT_VLD, RX_F3, RX_CELL_END, TX_OCT_REQ, TX_F3, TX_OAM_ONLY;
  wire NET_TIMING, STATE_EVT, LOM_F1, LOM_F3, LCD_OUT;
  int fail_count = 0;
  int samples_checked = 0;
  logic [15:0] d;
  logic [7:0] o;
  // 100 ns clock.
  always #50 CLK = ~CLK;
  cpom_top i_cpom_top (.*);
  cpom_peer i_cpom_peer (.*);
  // ***
  // Helpers
  // ***
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Waits are bounded; running out counts a mismatch and ends the run.
  task automatic wait_st(input logic [4:0] e);
    int n;
    n = 0;
    while (STATE !== e && n < 300) begin
      idle(1);
      n++;
    end
    chk("STATE", {11'h0, STATE}, {11'h0, e});
    if (n >= 300) tally_and_finish();
  endtask
  task automatic wait_flag(input int k, input logic e, input int lim);
    int n;
    n = 0;
    while (((k == 0) ? LCD_OUT : LOM_F1) !== e && n < lim) begin
      idle(1);
      n++;
    end
    chk("FLAG", {15'h0, (k == 0) ? LCD_OUT : LOM_F1}, {15'h0, e});
    if (n >= lim) tally_and_finish();
  endtask
  task automatic txc(input logic f3, input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
    i_cpom_peer.fetch(f3, i, o);
    chk("TX_OCT", {8'h0, o & m}, {8'h0, e});
  endtask
  // ***
  // Main sequence
  // ***
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rd(`CPOM_OFS_CTRL, d);
    chk("CTRL", d, `CPOM_CTRL_RST);
    rd(`CPOM_OFS_OAMGAP, d);
    chk("OAMGAP", d, `CPOM_GAP_RST);
    wr(4'h9, 16'hffff);
    rd(4'h9, d);
    chk("UNMAPPED", d, 16'h0);
    // User side, working, x of one millisecond; widest gap keeps flows alive.
    wr(`CPOM_OFS_CTRL, 16'h0006);
    wr(`CPOM_OFS_OAMGAP, 16'hffff);
    idle(20);
    chk("STATE", {11'h0, STATE}, {11'h0, `CPOM_F7});
    @(posedge CLK) DL_STATE <= `CPOM_DL_SYNC;
    wait_st(`CPOM_F1);
    chk("OAM_ONLY", {15'h0, TX_OAM_ONLY}, 16'h0);
    chk("NET_TIMING", {15'h0, NET_TIMING}, 16'h0);
    // Indications from the far end walk the user states.
    i_cpom_peer.send_cell(1'b1, 8'h00, 8'h03);
    wait_st(`CPOM_F2);
    chk("OAM_ONLY", {15'h0, TX_OAM_ONLY}, 16'h0);
    i_cpom_peer.send_cell(1'b0, `CPOM_F1_RSVD, 8'h03);
    wait_st(`CPOM_F5);
    chk("OAM_ONLY", {15'h0, TX_OAM_ONLY}, 16'h0);
    i_cpom_peer.send_cell(1'b1, 8'h03, 8'h03);
    wait_st(`CPOM_F6);
    chk("OAM_ONLY", {15'h0, TX_OAM_ONLY}, 16'h1);
    txc(1'b1, `CPOM_OCT_RDI, 8'hff, 8'h11);
    txc(1'b0, `CPOM_OCT_RDI, 8'hff, 8'h00);
    txc(1'b0, `CPOM_OCT_AIS, 8'hff, `CPOM_F1_RSVD);
    // Received octets latch beside the octets that would be sent.
    rd(`CPOM_OFS_PRDI, d);
    chk("PRDI_REG", d, 16'h0311);
    rd(`CPOM_OFS_PAIS, d);
    chk("PAIS_REG", d, 16'h0300);
    i_cpom_peer.send_cell(1'b0, `CPOM_F1_RSVD, 8'h00);
    wait_st(`CPOM_F4);
    txc(1'b1, `CPOM_OCT_RDI, 8'hff, 8'h11);
    i_cpom_peer.send_cell(1'b1, 8'h00, 8'h00);
    wait_st(`CPOM_F1);
    @(posedge CLK) LOS <= 1'b1;
    wait_st(`CPOM_F3);
    txc(1'b0, `CPOM_OCT_RDI, 8'hff, 8'h03);
    txc(1'b1, `CPOM_OCT_RDI, 8'hff, 8'h03);
    @(posedge CLK) LOS <= 1'b0;
    wait_st(`CPOM_F1);
    // Delineation loss; timings hold margin for the register pipeline.
    @(posedge CLK) DL_STATE <= `CPOM_DL_HUNT;
    rd(`CPOM_OFS_STATUS, d);
    chk("OCD", d & 16'h1, 16'h1);
    idle(9960);
    chk("LCD", {15'h0, LCD_OUT}, 16'h0);
    wait_flag(0, 1'b1, 60);
    rd(`CPOM_OFS_STATUS, d);
    chk("OCD", d & 16'h3, 16'h2);
    wait_st(`CPOM_F3);
    @(posedge CLK) DL_STATE <= `CPOM_DL_SYNC;
    idle(5000);
    @(posedge CLK) DL_STATE <= `CPOM_DL_PRESYNC;
    @(posedge CLK) DL_STATE <= `CPOM_DL_SYNC;
    idle(9960);
    chk("LCD", {15'h0, LCD_OUT}, 16'h1);
    wait_flag(0, 1'b0, 60);
    wait_st(`CPOM_F1);
    @(posedge CLK) DL_STATE <= `CPOM_DL_HUNT;
    @(posedge CLK) DL_STATE <= `CPOM_DL_PRESYNC;
    rd(`CPOM_OFS_STATUS, d);
    chk("OCD", d & 16'h1, 16'h1);
    @(posedge CLK) DL_STATE <= `CPOM_DL_SYNC;
    idle(3);
    rd(`CPOM_OFS_STATUS, d);
    chk("OCD", d & 16'h1, 16'h0);
    // Network side from power on through access and local faults.
    wr(`CPOM_OFS_CTRL, 16'h0007);
    wait_st(`CPOM_G1);
    chk("NET_TIMING", {15'h0, NET_TIMING}, 16'h1);
    @(posedge CLK) ACC_LCD <= 1'b1;
    wait_st(`CPOM_G2);
    txc(1'b1, `CPOM_OCT_RDI, 8'h01, 8'h01);
    txc(1'b0, `CPOM_OCT_RDI, 8'hff, 8'h00);
    @(posedge CLK) ACC_LOS <= 1'b1;
    wait_st(`CPOM_G4);
    chk("NET_TIMING", {15'h0, NET_TIMING}, 16'h0);
    txc(1'b1, `CPOM_OCT_AIS, 8'h01, 8'h01);
    @(posedge CLK) LOS <= 1'b1;
    wait_st(`CPOM_G10);
    txc(1'b1, `CPOM_OCT_AIS, 8'h01, 8'h01);
    txc(1'b0, `CPOM_OCT_RDI, 8'h01, 8'h01);
    @(posedge CLK) ACC_LOS <= 1'b0;
    ACC_LCD <= 1'b0;
    wait_st(`CPOM_G5);
    txc(1'b0, `CPOM_OCT_RDI, 8'hff, 8'h03);
    txc(1'b1, `CPOM_OCT_RDI, 8'h01, 8'h01);
    @(posedge CLK) LOS <= 1'b0;
    wait_st(`CPOM_G1);
    // Short gap: one miss must not declare loss, the second must.
    wr(`CPOM_OFS_OAMGAP, 16'h0010);
    i_cpom_peer.send_cell(1'b1, 8'h00, 8'h00);
    i_cpom_peer.send_cell(1'b0, `CPOM_F1_RSVD, 8'h00);
    idle(22);
    chk("LOM_F1", {15'h0, LOM_F1}, 16'h0);
    chk("LOM_F3", {15'h0, LOM_F3}, 16'h1);
    wait_flag(1, 1'b1, 40);
    wait_st(`CPOM_G5);
    rd(`CPOM_OFS_STATE, d);
    chk("STATE_REG", d, {11'h0, `CPOM_G5});
    tally_and_finish();
  end
endmodule // tb_cpom_top
`default_nettype wire
